// [hdl/power_query_config_overlay_cmd.sv]
`default_nettype none
module power_query_config_overlay_cmd
	import dco_pkg::*;
(
	input wire logic mclk,
	input wire logic rst,
	input wire logic por,
	input wire logic tf_cmd_valid,
	input wire tf_s tf_in,
	input wire logic spindle_at_speed,
	input wire logic standby_mode,
	input wire logic sleep_mode,
	input wire logic security_enabled,
	input wire logic hpa_active,
	output tf_result_s tf_out,
	output logic cmd_done,
	output logic pio_out_valid,
	output logic [DATA_W-1:0] pio_out_data,
	input wire logic pio_out_ready,
	input wire logic pio_in_valid,
	input wire logic [DATA_W-1:0] pio_in_data,
	output logic pio_in_ready,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq
);
	state_e state;
	logic [7:0] cnt;
	logic [7:0] commit_idx;
	logic commit_wv;
	logic init_walk;
	logic frozen;
	logic frozen_q;
	logic bad;
	logic [7:0] bad_reason;
	logic [7:0] bad_word;
	logic [7:0] bad_mid;
	logic is_query;
	logic is_overlay;
	logic sub_legal;
	logic take;
	logic freeze_ok;
	logic in_take;
	logic word_bad;
	logic [7:0] word_reason;
	logic [7:0] word_mid;
	logic mem_we;
	logic [ADDR_W-1:0] mem_waddr;
	logic [DATA_W-1:0] mem_wdata;
	logic [DATA_W-1:0] stage_rd;
	logic [DATA_W-1:0] cap_rd;
	logic [7:0] cap_sel;
	logic [IRQ_W-1:0] irq_status;
	logic [IRQ_W-1:0] irq_mask;
	logic [IRQ_W-1:0] irq_events;
	logic [IRQ_W-1:0] irq_clear;

	// ======================================
	// Command decode
	always_comb begin
		is_query = tf_in.command == OP_PWR_QUERY_A || tf_in.command == OP_PWR_QUERY_B;
		is_overlay = tf_in.command == OP_OVERLAY;
		sub_legal = tf_in.feature inside {SUB_RESTORE, SUB_FREEZE, SUB_IDENTIFY, SUB_SET};
		take = tf_cmd_valid && state == S_IDLE && (is_query || is_overlay);
		freeze_ok = take && is_overlay && tf_in.feature == SUB_FREEZE && !frozen;
		in_take = pio_in_valid && pio_in_ready;
		word_bad = 1'b0;
		word_reason = RSN_NONE;
		word_mid = RSN_NONE;
		if (cnt == W_REV && pio_in_data != CAP_REV) begin
			word_bad = 1'b1;
			word_reason = RSN_REV;
		end else if (cnt == W_FEAT && security_enabled && !pio_in_data[SEC_BIT]) begin
			word_bad = 1'b1;
			word_reason = RSN_SECURITY;
			word_mid = SEC_MID;
		end
	end

	// ======================================
	// Freeze condition, cleared by power-on only
	always_ff @(posedge mclk) begin
		if (por) begin
			frozen <= 1'b0;
			frozen_q <= 1'b0;
		end else begin
			frozen_q <= frozen;
			if (freeze_ok) begin
				frozen <= 1'b1;
			end
		end
	end

	// ======================================
	// Overlay memory write steering
	always_comb begin
		mem_we = 1'b0;
		mem_waddr = {LIVE, cnt};
		mem_wdata = cap_full(cnt);
		unique case (state)
			S_IDLE, S_SEND: begin
				mem_we = 1'b0;
			end
			S_RESTORE: begin
				mem_we = 1'b1;
			end
			S_RECV: begin
				mem_we = in_take;
				mem_waddr = {STAGE, cnt};
				mem_wdata = pio_in_data & cap_full(cnt);
			end
			S_COMMIT: begin
				mem_we = commit_wv;
				mem_waddr = {LIVE, commit_idx};
				mem_wdata = stage_rd;
			end
			default: begin
				mem_we = 1'b0;
			end
		endcase
	end

	overlay_store u_store (
		.mclk(mclk),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr_a({STAGE, cnt}),
		.rdata_a(stage_rd),
		.raddr_b({LIVE, cap_sel}),
		.rdata_b(cap_rd)
	);

	// ======================================
	// Command sequencer
	always_ff @(posedge mclk) begin
		if (por || rst) begin
			state <= (por || init_walk) ? S_RESTORE : S_IDLE;
			if (por) begin
				init_walk <= 1'b1;
			end
			cnt <= WORD_FIRST;
			commit_idx <= WORD_FIRST;
			commit_wv <= 1'b0;
			bad <= 1'b0;
			bad_reason <= RSN_NONE;
			bad_word <= RSN_NONE;
			bad_mid <= RSN_NONE;
			tf_out <= RESULT_OK;
			cmd_done <= 1'b0;
			pio_out_valid <= 1'b0;
			pio_out_data <= CAP_NONE;
			pio_in_ready <= 1'b0;
		end else begin
			cmd_done <= 1'b0;
			commit_wv <= 1'b0;
			unique case (state)
				S_IDLE: begin
					cnt <= WORD_FIRST;
					if (take && is_query) begin
						tf_out <= RESULT_OK;
						if (spindle_at_speed && !standby_mode && !sleep_mode) begin
							tf_out.sector_count <= PWR_ACTIVE;
						end else begin
							tf_out.sector_count <= PWR_LOW;
						end
						cmd_done <= 1'b1;
					end else if (take) begin
						if (!sub_legal || frozen) begin
							tf_out <= '{error: ERR_ABORT, status: ST_FAIL, sector_count: RSN_NONE,
								lba_mid: RSN_NONE, lba_high: RSN_NONE};
							cmd_done <= 1'b1;
						end else if (tf_in.feature == SUB_FREEZE) begin
							tf_out <= RESULT_OK;
							cmd_done <= 1'b1;
						end else if (tf_in.feature == SUB_RESTORE) begin
							if (hpa_active) begin
								tf_out <= '{error: ERR_ABORT, status: ST_FAIL, sector_count: RSN_PROTECTED,
									lba_mid: RSN_NONE, lba_high: W_MAXLBA};
								cmd_done <= 1'b1;
							end else begin
								tf_out.status <= ST_BUSY;
								state <= S_RESTORE;
							end
						end else if (tf_in.feature == SUB_IDENTIFY) begin
							tf_out.status <= ST_XFER;
							pio_out_valid <= 1'b1;
							pio_out_data <= cap_full(WORD_FIRST);
							state <= S_SEND;
						end else begin
							tf_out.status <= ST_XFER;
							pio_in_ready <= 1'b1;
							bad <= 1'b0;
							state <= S_RECV;
						end
					end
				end
				S_SEND: begin
					if (pio_out_ready) begin
						if (cnt == WORD_LAST) begin
							pio_out_valid <= 1'b0;
							tf_out <= RESULT_OK;
							cmd_done <= 1'b1;
							state <= S_IDLE;
						end else begin
							cnt <= cnt + 8'h01;
							pio_out_data <= cap_full(cnt + 8'h01);
						end
					end
				end
				S_RECV: begin
					if (in_take) begin
						cnt <= cnt + 8'h01;
						if (!bad && word_bad) begin
							bad <= 1'b1;
							bad_reason <= word_reason;
							bad_word <= cnt;
							bad_mid <= word_mid;
						end
						if (cnt == WORD_LAST) begin
							pio_in_ready <= 1'b0;
							cnt <= WORD_FIRST;
							if (hpa_active) begin
								tf_out <= '{error: ERR_ABORT, status: ST_FAIL, sector_count: RSN_PROTECTED,
									lba_mid: RSN_NONE, lba_high: W_MAXLBA};
								cmd_done <= 1'b1;
								state <= S_IDLE;
							end else if (bad) begin
								tf_out <= '{error: ERR_ABORT, status: ST_FAIL, sector_count: bad_reason,
									lba_mid: bad_mid, lba_high: bad_word};
								cmd_done <= 1'b1;
								state <= S_IDLE;
							end else if (word_bad) begin
								tf_out <= '{error: ERR_ABORT, status: ST_FAIL, sector_count: word_reason,
									lba_mid: word_mid, lba_high: cnt};
								cmd_done <= 1'b1;
								state <= S_IDLE;
							end else begin
								tf_out.status <= ST_BUSY;
								state <= S_COMMIT;
							end
						end
					end
				end
				S_COMMIT: begin
					if (cnt != WORD_LAST) begin
						cnt <= cnt + 8'h01;
					end
					commit_idx <= cnt;
					commit_wv <= 1'b1;
					if (commit_wv && commit_idx == WORD_LAST) begin
						commit_wv <= 1'b0;
						cnt <= WORD_FIRST;
						tf_out <= RESULT_OK;
						cmd_done <= 1'b1;
						state <= S_IDLE;
					end
				end
				S_RESTORE: begin
					cnt <= cnt + 8'h01;
					if (cnt == WORD_LAST) begin
						init_walk <= 1'b0;
						cnt <= WORD_FIRST;
						state <= S_IDLE;
						if (!init_walk) begin
							tf_out <= RESULT_OK;
							cmd_done <= 1'b1;
						end
					end
				end
				default: begin
					state <= S_IDLE;
				end
			endcase
		end
	end

	// ======================================
	// Interrupt status and mask
	always_comb begin
		irq_events = {frozen && !frozen_q, cmd_done && tf_out.error[ER_ABORT], cmd_done};
		irq_clear = (reg_wr && reg_addr == R_IRQ_STATUS) ? reg_wdata[IRQ_W-1:0] : '0;
	end

	always_ff @(posedge mclk) begin
		if (por || rst) begin
			irq_status <= '0;
			irq <= 1'b0;
		end else begin
			// Set wins over a clear in the same cycle
			irq_status <= (irq_status & ~irq_clear) | irq_events;
			irq <= |(irq_status & irq_mask);
		end
	end

	// ======================================
	// Register port
	always_ff @(posedge mclk) begin
		if (por || rst) begin
			irq_mask <= '0;
			cap_sel <= WORD_FIRST;
			reg_rdata <= '0;
		end else begin
			reg_rdata <= '0;
			if (reg_wr && reg_addr == R_IRQ_MASK) begin
				irq_mask <= reg_wdata[IRQ_W-1:0];
			end
			if (reg_wr && reg_addr == R_CAP_SEL) begin
				cap_sel <= reg_wdata[7:0];
			end
			if (reg_rd) begin
				case (reg_addr)
					R_IRQ_STATUS: reg_rdata <= 32'(irq_status);
					R_IRQ_MASK: reg_rdata <= 32'(irq_mask);
					R_STATE: reg_rdata <= 32'({state != S_IDLE, frozen});
					R_CAP_SEL: reg_rdata <= 32'(cap_sel);
					R_CAP_DATA: reg_rdata <= 32'(cap_rd);
					default: reg_rdata <= '0;
				endcase
			end
		end
	end

	// ======================================
	// Assertions
	default clocking @(posedge mclk); endclocking
	default disable iff (rst || por);

	property p_query_active;
		take && is_query && spindle_at_speed && !standby_mode && !sleep_mode
			|=> cmd_done && tf_out.sector_count == PWR_ACTIVE && tf_out.error == ERR_NONE;
	endproperty
	a_query_active: assert property (p_query_active) else $error("query not FFh");

	property p_query_low;
		take && is_query && !(spindle_at_speed && !standby_mode && !sleep_mode)
			|=> cmd_done && tf_out.sector_count == PWR_LOW;
	endproperty
	a_query_low: assert property (p_query_low) else $error("query not zero");

	property p_query_alt;
		tf_cmd_valid && state == S_IDLE && tf_in.command == OP_PWR_QUERY_B |=> cmd_done ##1 !cmd_done;
	endproperty
	a_query_alt: assert property (p_query_alt) else $error("alternate query opcode missed");

	property p_reserved_abort;
		take && is_overlay && !sub_legal |=> cmd_done && tf_out.error[ER_ABORT] && tf_out.status == ST_FAIL;
	endproperty
	a_reserved_abort: assert property (p_reserved_abort) else $error("reserved feature ran");

	property p_frozen_abort;
		take && is_overlay && frozen |=> cmd_done && tf_out.error[ER_ABORT] && state == S_IDLE;
	endproperty
	a_frozen_abort: assert property (p_frozen_abort) else $error("frozen subcommand ran");

	property p_freeze_hold;
		frozen |=> frozen;
	endproperty
	a_freeze_hold: assert property (@(posedge mclk) disable iff (por) p_freeze_hold)
		else $error("freeze lost");

	property p_identify_end;
		state == S_SEND && pio_out_ready && cnt == WORD_LAST |=> !pio_out_valid && cmd_done && state == S_IDLE;
	endproperty
	a_identify_end: assert property (p_identify_end) else $error("identify length wrong");

	property p_restore_end;
		state == S_RESTORE && cnt == WORD_LAST && !init_walk |=> cmd_done && !tf_out.error[ER_ABORT];
	endproperty
	a_restore_end: assert property (p_restore_end) else $error("restore did not finish");

	property p_set_protected;
		state == S_RECV && in_take && cnt == WORD_LAST && hpa_active
			|=> cmd_done && tf_out.sector_count == RSN_PROTECTED && tf_out.lba_high == W_MAXLBA;
	endproperty
	a_set_protected: assert property (p_set_protected) else $error("set abort info wrong");

	property p_recv_masked;
		state == S_COMMIT && commit_wv |-> (stage_rd & ~cap_full(commit_idx)) == CAP_NONE;
	endproperty
	a_recv_masked: assert property (p_recv_masked) else $error("unsupported bit staged");

	c_query: cover property (take && is_query ##1 cmd_done);
	c_freeze: cover property (freeze_ok ##1 frozen);
	c_set_commit: cover property (state == S_COMMIT ##1 state == S_COMMIT [*8]);
	c_identify: cover property (state == S_SEND && cnt == WORD_LAST && pio_out_ready);
endmodule
`default_nettype wire

// [inc/dco_pkg.sv]
`default_nettype none
package dco_pkg;
	// ======================================
	// Opcodes and subcommands
	localparam logic [7:0] OP_PWR_QUERY_A = 8'he5;
	localparam logic [7:0] OP_PWR_QUERY_B = 8'h98;
	localparam logic [7:0] OP_OVERLAY = 8'hb1;
	localparam logic [7:0] SUB_RESTORE = 8'hc0;
	localparam logic [7:0] SUB_FREEZE = 8'hc1;
	localparam logic [7:0] SUB_IDENTIFY = 8'hc2;
	localparam logic [7:0] SUB_SET = 8'hc3;
	localparam logic [7:0] PWR_ACTIVE = 8'hff;
	localparam logic [7:0] PWR_LOW = 8'h00;
	// ======================================
	// Task-file flag values
	localparam int ER_ABORT = 2;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_ABORT = 8'h04;
	localparam logic [7:0] ST_OK = 8'h40;
	localparam logic [7:0] ST_FAIL = 8'h41;
	localparam logic [7:0] ST_BUSY = 8'h80;
	localparam logic [7:0] ST_XFER = 8'h48;
	// ======================================
	// Overlay words and abort reasons
	localparam int DATA_W = 16;
	localparam int ADDR_W = 9;
	localparam int DEPTH = 512;
	localparam logic LIVE = 1'b0;
	localparam logic STAGE = 1'b1;
	localparam logic [7:0] WORD_FIRST = 8'h00;
	localparam logic [7:0] WORD_LAST = 8'hff;
	localparam logic [7:0] W_REV = 8'h00;
	localparam logic [7:0] W_MDMA = 8'h01;
	localparam logic [7:0] W_UDMA = 8'h02;
	localparam logic [7:0] W_MAXLBA = 8'h03;
	localparam logic [7:0] W_FEAT = 8'h07;
	localparam logic [15:0] CAP_REV = 16'h0002;
	localparam logic [15:0] CAP_MDMA = 16'h0007;
	localparam logic [15:0] CAP_UDMA = 16'h003f;
	localparam logic [15:0] CAP_FEAT = 16'h01ff;
	localparam logic [15:0] CAP_NONE = 16'h0000;
	localparam int SEC_BIT = 3;
	localparam logic [7:0] SEC_MID = 8'h08;
	localparam logic [7:0] RSN_NONE = 8'h00;
	localparam logic [7:0] RSN_REV = 8'h01;
	localparam logic [7:0] RSN_SECURITY = 8'h04;
	localparam logic [7:0] RSN_PROTECTED = 8'h06;
	// ======================================
	// Register map
	localparam logic [7:0] R_IRQ_STATUS = 8'h00;
	localparam logic [7:0] R_IRQ_MASK = 8'h04;
	localparam logic [7:0] R_STATE = 8'h08;
	localparam logic [7:0] R_CAP_SEL = 8'h0c;
	localparam logic [7:0] R_CAP_DATA = 8'h10;
	localparam int IRQ_W = 3;
	// ======================================
	// Types
	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_SEND = 3'h1,
		S_RECV = 3'h3,
		S_COMMIT = 3'h2,
		S_RESTORE = 3'h6
	} state_e;
	typedef struct packed {
		logic [7:0] feature;
		logic [7:0] sector_count;
		logic [7:0] lba_low;
		logic [7:0] lba_mid;
		logic [7:0] lba_high;
		logic [7:0] device;
		logic [7:0] command;
	} tf_s;
	typedef struct packed {
		logic [7:0] error;
		logic [7:0] status;
		logic [7:0] sector_count;
		logic [7:0] lba_mid;
		logic [7:0] lba_high;
	} tf_result_s;
	localparam tf_result_s RESULT_OK = '{error: ERR_NONE, status: ST_OK, sector_count: RSN_NONE,
		lba_mid: RSN_NONE, lba_high: RSN_NONE};
	// Full selectable capability set
	function automatic logic [15:0] cap_full(input logic [7:0] idx);
		case (idx)
			W_REV: cap_full = CAP_REV;
			W_MDMA: cap_full = CAP_MDMA;
			W_UDMA: cap_full = CAP_UDMA;
			W_FEAT: cap_full = CAP_FEAT;
			default: cap_full = CAP_NONE;
		endcase
	endfunction
endpackage
`default_nettype wire

// [hdl/overlay_store.sv]
`default_nettype none
module overlay_store
	import dco_pkg::*;
(
	input wire logic mclk,
	input wire logic we,
	input wire logic [ADDR_W-1:0] waddr,
	input wire logic [DATA_W-1:0] wdata,
	input wire logic [ADDR_W-1:0] raddr_a,
	output logic [DATA_W-1:0] rdata_a,
	input wire logic [ADDR_W-1:0] raddr_b,
	output logic [DATA_W-1:0] rdata_b
);
	// ======================================
	// Live overlay in low half, staged set data in high half
	logic [DATA_W-1:0] mem [0:DEPTH-1];

	always_ff @(posedge mclk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge mclk) begin
		rdata_a <= mem[raddr_a];
		rdata_b <= mem[raddr_b];
	end
endmodule
`default_nettype wire

// [testbench/host_model.sv]
`default_nettype none
module host_model
	import dco_pkg::*;
(
	input wire logic mclk,
	output var logic tf_cmd_valid,
	output var tf_s tf_in,
	input wire logic pio_out_valid,
	input wire logic [DATA_W-1:0] pio_out_data,
	output var logic pio_out_ready,
	output var logic pio_in_valid,
	output var logic [DATA_W-1:0] pio_in_data,
	input wire logic pio_in_ready
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed = 38;
	int in_idx = 256;
	int out_cnt = 0;
	logic [DATA_W-1:0] set_buf [256];
	logic [DATA_W-1:0] out_buf [256];
	initial begin
		tf_cmd_valid = 1'b0;
		tf_in = '0;
		pio_out_ready = 1'b0;
		pio_in_valid = 1'b0;
		pio_in_data = '0;
	end
	// ======================================
	// Command issue
	task automatic issue(input logic [7:0] op, input logic [7:0] feat);
		@(posedge mclk);
		tf_cmd_valid <= 1'b1;
		tf_in <= {feat, 8'($random(seed)), 32'($random(seed)), op};
		@(posedge mclk);
		tf_cmd_valid <= 1'b0;
		tf_in <= ~tf_in;
	endtask
	// ======================================
	// Data-in side, stalls at random
	always @(posedge mclk) begin
		if (pio_out_valid && pio_out_ready && out_cnt < 256) begin
			out_buf[out_cnt] = pio_out_data;
			out_cnt = out_cnt + 1;
		end
		pio_out_ready <= 1'($random(seed));
	end
	// ======================================
	// Data-out side, word held until taken
	always @(posedge mclk) begin
		if (pio_in_valid && pio_in_ready)
			in_idx = in_idx + 1;
		if (!pio_in_valid || pio_in_ready) begin
			if (in_idx < 256 && 1'($random(seed))) begin
				pio_in_valid <= 1'b1;
				pio_in_data <= set_buf[in_idx];
			end else begin
				pio_in_valid <= 1'b0;
				pio_in_data <= ~pio_in_data;
			end
		end
	end
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
`default_nettype none
module tb_top
	import dco_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic rst = 1'b1;
	logic por = 1'b1;
	logic spindle_at_speed = 1'b1;
	logic standby_mode = 1'b0;
	logic sleep_mode = 1'b0;
	logic security_enabled = 1'b0;
	logic hpa_active = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic tf_cmd_valid, cmd_done, pio_out_valid, pio_out_ready, pio_in_valid, pio_in_ready, irq;
	logic [DATA_W-1:0] pio_out_data, pio_in_data;
	logic [31:0] reg_rdata, rd;
	logic [7:0] f, e;
	tf_s tf_in;
	tf_result_s tf_out;
	int mismatches = 0;
	int checks_done = 0;
	int seed = 38;
	power_query_config_overlay_cmd dut (.mclk, .rst, .por, .tf_cmd_valid, .tf_in, .spindle_at_speed,
		.standby_mode, .sleep_mode, .security_enabled, .hpa_active, .tf_out, .cmd_done, .pio_out_valid,
		.pio_out_data, .pio_out_ready, .pio_in_valid, .pio_in_data, .pio_in_ready, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .irq);
	host_model host (.mclk, .tf_cmd_valid, .tf_in, .pio_out_valid, .pio_out_data, .pio_out_ready,
		.pio_in_valid, .pio_in_data, .pio_in_ready);
	initial begin
		forever #20 mclk = ~mclk;
	end
	// ======================================
	// Checking and closing
	task automatic chk(input string name, input logic [39:0] exp, input logic [39:0] got);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_sim();
		$display("mismatches %0d checks_done %0d", mismatches, checks_done);
		if (mismatches == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	function automatic logic [15:0] exp_cap(input int i);
		return i == 0 ? CAP_REV : i == 1 ? CAP_MDMA : i == 2 ? CAP_UDMA : i == 7 ? CAP_FEAT : CAP_NONE;
	endfunction
	// ======================================
	// Bus and command tasks
	task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
		@(posedge mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge mclk);
		reg_rd <= 1'b0;
		@(negedge mclk);
		d = reg_rdata;
	endtask
	task automatic run(input logic [7:0] op, input logic [7:0] feat);
		int n;
		host.issue(op, feat);
		for (n = 0; n < 4000; n++) begin
			@(negedge mclk);
			if (cmd_done === 1'b1)
				break;
		end
		if (n == 4000) begin
			mismatches++;
			$display("[ERR] cmd_done expected 1 seen 0");
			end_sim();
		end
	endtask
	task automatic load_set(input logic [15:0] w0, input logic [15:0] w1, input logic [15:0] w7);
		for (int i = 0; i < 256; i++)
			host.set_buf[i] = exp_cap(i);
		host.set_buf[0] = w0;
		host.set_buf[1] = w1;
		host.set_buf[2] = 16'hffff;
		host.set_buf[7] = w7;
		host.in_idx = 0;
	endtask
	task automatic identify_full();
		host.out_cnt = 0;
		run(OP_OVERLAY, SUB_IDENTIFY);
		chk("id_count", 40'd256, 40'(host.out_cnt));
		for (int i = 0; i < 256; i++)
			chk("id_word", 40'(exp_cap(i)), 40'(host.out_buf[i]));
	endtask
	task automatic cap_chk(input int i, input logic [15:0] x);
		reg_write(R_CAP_SEL, 32'(i));
		repeat (2) @(posedge mclk);
		reg_read(R_CAP_DATA, rd);
		chk("cap_data", 40'(x), 40'(rd));
	endtask
	task automatic try_abort(input logic [7:0] ft, input logic [15:0] w0, input logic [15:0] w7, input logic sec,
		input logic hpa, input logic [7:0] rsn, input logic [7:0] hi, input logic [7:0] mid);
		@(posedge mclk);
		security_enabled <= sec;
		hpa_active <= hpa;
		if (ft == SUB_SET)
			load_set(w0, 16'h0001, w7);
		run(OP_OVERLAY, ft);
		chk("abort_result", {ERR_ABORT, ST_FAIL, rsn, mid, hi}, tf_out);
		@(posedge mclk);
		security_enabled <= 1'b0;
		hpa_active <= 1'b0;
	endtask
	initial begin
		repeat (100000) @(posedge mclk);
		mismatches++;
		$display("[ERR] run_time expected end seen limit");
		end_sim();
	end
	// ======================================
	// Main sequence
	initial begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		por <= 1'b0;
		repeat (260) @(posedge mclk);
		reg_read(R_STATE, rd);
		chk("state_idle", 40'h0, 40'(rd));
		for (int i = 0; i < 12; i++) begin
			@(posedge mclk);
			spindle_at_speed <= i < 3 || 1'($random(seed));
			standby_mode <= i >= 3 && 1'($random(seed));
			sleep_mode <= i >= 3 && 1'($random(seed));
			run(i[0] ? OP_PWR_QUERY_B : OP_PWR_QUERY_A, 8'($random(seed)));
			e = (spindle_at_speed && !standby_mode && !sleep_mode) ? PWR_ACTIVE : PWR_LOW;
			chk("query", {ERR_NONE, ST_OK, e}, tf_out[39:16]);
		end
		for (int i = 0; i < 6; i++) begin
			f = i == 0 ? 8'hbf : i == 1 ? 8'hc4 : 8'($random(seed));
			if (f[7:2] == 6'h30)
				f = f ^ 8'h10;
			run(OP_OVERLAY, f);
			chk("reserved", {ERR_ABORT, ST_FAIL, 24'h0}, tf_out);
		end
		identify_full();
		load_set(CAP_REV, 16'h0003, CAP_FEAT);
		run(OP_OVERLAY, SUB_SET);
		chk("set_ok", RESULT_OK, tf_out);
		cap_chk(1, 16'h0003);
		cap_chk(2, CAP_UDMA);
		identify_full();
		run(OP_OVERLAY, SUB_RESTORE);
		chk("restore_ok", RESULT_OK, tf_out);
		cap_chk(1, CAP_MDMA);
		try_abort(SUB_SET, 16'h0001, CAP_FEAT, 0, 0, RSN_REV, W_REV, 8'h00);
		try_abort(SUB_SET, CAP_REV, 16'h01f7, 1, 0, RSN_SECURITY, W_FEAT, SEC_MID);
		try_abort(SUB_SET, CAP_REV, CAP_FEAT, 0, 1, RSN_PROTECTED, W_MAXLBA, 8'h00);
		try_abort(SUB_RESTORE, CAP_REV, CAP_FEAT, 0, 1, RSN_PROTECTED, W_MAXLBA, 8'h00);
		cap_chk(1, CAP_MDMA);
		reg_write(R_IRQ_STATUS, 32'h7);
		reg_write(R_IRQ_MASK, 32'h1);
		run(OP_PWR_QUERY_A, 8'h00);
		repeat (3) @(negedge mclk);
		chk("irq_done", 40'h1, 40'(irq));
		reg_read(R_IRQ_STATUS, rd);
		chk("irq_status", 40'h1, 40'(rd));
		reg_write(R_IRQ_STATUS, 32'h1);
		reg_write(R_IRQ_MASK, 32'h2);
		run(OP_PWR_QUERY_B, 8'h00);
		repeat (3) @(negedge mclk);
		chk("irq_masked", 40'h0, 40'(irq));
		run(OP_OVERLAY, 8'h00);
		repeat (3) @(negedge mclk);
		chk("irq_abort", 40'h1, 40'(irq));
		reg_write(R_IRQ_STATUS, 32'h7);
		repeat (3) @(negedge mclk);
		chk("irq_clear", 40'h0, 40'(irq));
		reg_read(8'h40, rd);
		chk("unmapped", 40'h0, 40'(rd));
		run(OP_OVERLAY, SUB_FREEZE);
		chk("freeze_ok", RESULT_OK, tf_out);
		reg_read(R_IRQ_STATUS, rd);
		chk("irq_freeze", 40'h5, 40'(rd));
		for (int k = 0; k < 2; k++) begin
			for (int s = 0; s < 4; s++) begin
				run(OP_OVERLAY, SUB_RESTORE + 8'(s));
				chk("frozen", {ERR_ABORT, ST_FAIL, 24'h0}, tf_out);
			end
			reg_read(R_STATE, rd);
			chk("frozen_state", 40'h1, 40'(rd));
			@(posedge mclk);
			rst <= 1'b1;
			repeat (3) @(posedge mclk);
			rst <= 1'b0;
			@(negedge mclk);
			chk("rst_result", RESULT_OK, tf_out);
		end
		@(posedge mclk);
		por <= 1'b1;
		repeat (3) @(posedge mclk);
		por <= 1'b0;
		repeat (260) @(posedge mclk);
		reg_read(R_STATE, rd);
		chk("thawed_state", 40'h0, 40'(rd));
		identify_full();
		end_sim();
	end
endmodule
`default_nettype wire
